// ---- rtl/mdfs_regs.sv ----
// fault and warning status register bank with apb slave and interrupt
//
// Functional notes
// - buck_low_fault follows buck output below 80% of nominal.
// - buck_low_warning follows buck output below 90% of nominal.
// - buck_input_overcurrent_warning follows buck input current above 2A peak.
// - supply_overvoltage_fault follows supply above 32V, else zero.
// - driver_overvoltage_fault follows driver supply above 20V; zero without monitor.
// - supply_undervoltage_fault follows supply below 5.5V.
// - overtemp_fault follows junction above 160 C.
// - overtemp_warning follows junction above 115 C.
// - five_volt_reg_low_fault follows 5V regulator below 4.0V.
// - brownout_config_lost resets to one; other status bits reset to zero.
// - brownout_config_lost set by internal reset since last configuration.
// - ext_fet_overcurrent_fault follows Vds above selected overcurrent limit.
// - gate_drive_low_fault follows any high-side gate output below 8V.
// - status b bits 7:6 and 1:0 read as zero.
// - limit field 00..11 selects 0.250, 0.500, 0.750, 1.000 V.
`timescale 1ns/10ps
`default_nettype none

module mdfs_regs #(
  parameter bit HAS_DRIVER_OVP = 1'b1
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [mdfs_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [mdfs_pkg::DATA_W-1:0]   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic      [mdfs_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire mdfs_pkg::mdfs_mon_t           monitors,
  output mdfs_pkg::mdfs_cfg_t                cfg,
  output logic                               irq
);

  // ************************************************************
  // register map
  // ************************************************************
  // 00 status a    read only, live monitor levels
  // 04 status b    read only, brownout flag sticky, bits 7:6 and 1:0 zero
  // 08 irq status  read only, {status b, status a} layout, a read clears what it returned
  // 0C irq mask    read/write, same layout as irq status
  // 10 config      read/write, [1:0] limit select, [2] short detect
  // status a bits: 7 buck low fault, 6 buck low warning, 5 buck input overcurrent,
  //   4 supply overvoltage, 3 driver overvoltage, 2 supply undervoltage,
  //   1 overtemp fault, 0 overtemp warning
  // status b bits: 5 five volt regulator low, 4 brownout config lost,
  //   3 external fet overcurrent, 2 gate drive low
  // every register is one aligned word; unused upper bits read zero.
  // no wait states: read data is captured in the setup cycle, so a read shows
  // status as it stood one cycle before the access edge; a monitor change
  // becomes visible in status three edges after it settles at the input.

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0]                 status_a;
    logic [7:0]                 status_b;
    logic                       reset_seen;
    logic [15:0]                irq_status;
    logic [15:0]                irq_mask;
    mdfs_pkg::mdfs_cfg_t        cfg;
    logic [mdfs_pkg::DATA_W-1:0] rdata;
    logic                       slverr;
    logic                       irq;
  } mdfs_state_t;

  mdfs_state_t state_reg;
  mdfs_state_t state_next;

  mdfs_pkg::mdfs_mon_t mon_sync;
  logic [mdfs_pkg::MON_W-1:0] mon_sync_bits;

  // ************************************************************
  // monitor synchronisation
  // ************************************************************
  // every comparator output is asynchronous to pclk
  // one shared synchroniser is enough: each flag is a level, so bits that
  // settle on different edges only delay one read, they never latch a wrong value
  mdfs_sync #(
    .W (mdfs_pkg::MON_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (monitors),
    .sync_out (mon_sync_bits)
  );

  assign mon_sync = mdfs_pkg::mdfs_mon_t'(mon_sync_bits);

  // ************************************************************
  // functions
  // ************************************************************
  // true when the offset names an implemented register
  function automatic logic addr_mapped(input logic [mdfs_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    case (a)
      mdfs_pkg::STATUS_A_OFFSET:   hit = 1'b1;
      mdfs_pkg::STATUS_B_OFFSET:   hit = 1'b1;
      mdfs_pkg::IRQ_STATUS_OFFSET: hit = 1'b1;
      mdfs_pkg::IRQ_MASK_OFFSET:   hit = 1'b1;
      mdfs_pkg::CONFIG_OFFSET:     hit = 1'b1;
      default:                     hit = 1'b0;
    endcase
    return hit;
  endfunction

  // merge write data into a byte-laned register image
  // only lanes 0 and 1 exist; pstrb[3:2] are ignored
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = new_v[7:0];
    end
    if (strb[1]) begin
      res[15:8] = new_v[15:8];
    end
    return res;
  endfunction

  // pick the comparator that matches the selected overcurrent limit
  // all thresholds are watched at once, so a new limit takes effect on the
  // next status update without waiting for the synchroniser
  function automatic logic oc_compare(input logic [1:0] sel,
                                      input logic [3:0] above);
    logic r;
    r = 1'b0;
    case (sel)
      mdfs_pkg::OC_LIMIT_0V250: r = above[0];
      mdfs_pkg::OC_LIMIT_0V500: r = above[1];
      mdfs_pkg::OC_LIMIT_0V750: r = above[2];
      mdfs_pkg::OC_LIMIT_1V000: r = above[3];
      default:                  r = 1'b0;
    endcase
    return r;
  endfunction

  // ************************************************************
  // live flag images
  // ************************************************************
  logic [7:0] live_a;
  logic [7:0] live_b;
  logic       reset_rise;
  logic       reset_prev;

  always_comb begin
    live_a = 8'h00;
    live_a[mdfs_pkg::A_BUCK_LOW_FAULT_BIT]     = mon_sync.buck_low_fault;
    live_a[mdfs_pkg::A_BUCK_LOW_WARNING_BIT]   = mon_sync.buck_low_warning;
    live_a[mdfs_pkg::A_BUCK_INPUT_OC_WARN_BIT] = mon_sync.buck_input_overcurrent_warning;
    live_a[mdfs_pkg::A_SUPPLY_OV_FAULT_BIT]    = mon_sync.supply_overvoltage_fault;
    // without the driver supply monitor its input may float; the parameter pins the bit low
    live_a[mdfs_pkg::A_DRIVER_OV_FAULT_BIT]    = HAS_DRIVER_OVP &&
                                                 mon_sync.driver_overvoltage_fault;
    live_a[mdfs_pkg::A_SUPPLY_UV_FAULT_BIT]    = mon_sync.supply_undervoltage_fault;
    live_a[mdfs_pkg::A_OVERTEMP_FAULT_BIT]     = mon_sync.overtemp_fault;
    live_a[mdfs_pkg::A_OVERTEMP_WARNING_BIT]   = mon_sync.overtemp_warning;
  end

  // brownout flag is kept separately; it is sticky, not a live level
  // the edge detector resets to the idle level of internal_reset (low),
  // so leaving reset never fakes a reset event
  assign reset_prev = state_reg.reset_seen;
  assign reset_rise = mon_sync.internal_reset && !reset_prev;

  always_comb begin
    live_b = 8'h00;
    live_b[mdfs_pkg::B_FIVE_VOLT_LOW_BIT]    = mon_sync.five_volt_reg_low_fault;
    live_b[mdfs_pkg::B_BROWNOUT_LOST_BIT]    = state_reg.status_b[mdfs_pkg::B_BROWNOUT_LOST_BIT];
    // the flag is produced regardless of the detect setting; the host qualifies it
    live_b[mdfs_pkg::B_EXT_FET_OC_FAULT_BIT] = oc_compare(state_reg.cfg.overcurrent_limit_select,
                                                          mon_sync.vds_above_limit);
    live_b[mdfs_pkg::B_GATE_DRIVE_LOW_BIT]   = mon_sync.gate_drive_low_fault;
  end

  // ************************************************************
  // bus decode
  // ************************************************************
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic rd_access;
  logic mapped;
  logic cfg_write;

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign mapped       = addr_mapped(paddr);
  assign wr_access    = access_phase && pwrite && mapped;
  assign rd_access    = access_phase && !pwrite && mapped;
  // lane 0 qualifies the config write; a write with no lanes set changes
  // nothing, not even the brownout flag
  assign cfg_write    = wr_access && (paddr == mdfs_pkg::CONFIG_OFFSET) && pstrb[0];

  // ************************************************************
  // next state
  // ************************************************************
  logic [15:0] irq_events;
  logic [15:0] old_flags;
  logic [15:0] new_flags;

  always_comb begin
    state_next = state_reg;

    // ----- status registers follow their monitors
    state_next.status_a = live_a;
    state_next.status_b = live_b & mdfs_pkg::STATUS_B_IMPL_MASK;

    // ----- brownout flag: set by internal reset, cleared by configuration
    state_next.reset_seen = mon_sync.internal_reset;
    if (cfg_write) begin
      state_next.status_b[mdfs_pkg::B_BROWNOUT_LOST_BIT] = 1'b0;
    end
    // set wins over a configuration write in the same cycle
    if (reset_rise) begin
      state_next.status_b[mdfs_pkg::B_BROWNOUT_LOST_BIT] = 1'b1;
    end

    // ----- interrupt events: a flag that rises
    // a falling flag is not an event: software sees it in the status register
    old_flags  = {state_reg.status_b, state_reg.status_a};
    new_flags  = {state_next.status_b, state_next.status_a};
    irq_events = new_flags & ~old_flags;

    // ----- register writes
    if (wr_access) begin
      case (paddr)
        mdfs_pkg::IRQ_MASK_OFFSET: begin
          state_next.irq_mask = lane_merge(state_reg.irq_mask, pwdata[15:0], pstrb[1:0]);
        end
        mdfs_pkg::CONFIG_OFFSET: begin
          // the config word stands in for the configuration message; any
          // accepted write with lane 0 counts as a new configuration
          if (pstrb[0]) begin
            state_next.cfg.overcurrent_limit_select =
              pwdata[mdfs_pkg::CFG_OC_LIMIT_LSB +: 2];
            state_next.cfg.short_circuit_detect_cfg =
              pwdata[mdfs_pkg::CFG_SHORT_DETECT_BIT];
          end
        end
        mdfs_pkg::STATUS_A_OFFSET,
        mdfs_pkg::STATUS_B_OFFSET,
        mdfs_pkg::IRQ_STATUS_OFFSET: begin
          // read-only targets: the write is dropped without an error response
          state_next.irq_mask = state_reg.irq_mask;
        end
        default: begin
          state_next.irq_mask = state_reg.irq_mask;
        end
      endcase
    end

    // ----- interrupt status: a read clears only what it returned, a new event wins
    if (rd_access && (paddr == mdfs_pkg::IRQ_STATUS_OFFSET)) begin
      // an event that lands during the setup cycle is not in the returned
      // word, so it must survive the clear
      state_next.irq_status = state_reg.irq_status & ~state_reg.rdata[15:0];
    end
    state_next.irq_status = state_next.irq_status | irq_events;

    // ----- interrupt output from a flop, aligned with the status it reports
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);

    // ----- read data captured in the setup phase, shown in the access phase
    // this gives prdata a full cycle of slack, at the cost of one cycle of age
    if (setup_phase) begin
      state_next.slverr = !mapped;
      state_next.rdata  = '0;
      if (!pwrite) begin
        case (paddr)
          mdfs_pkg::STATUS_A_OFFSET: begin
            state_next.rdata[7:0] = state_reg.status_a;
          end
          mdfs_pkg::STATUS_B_OFFSET: begin
            state_next.rdata[7:0] = state_reg.status_b;
          end
          mdfs_pkg::IRQ_STATUS_OFFSET: begin
            state_next.rdata[15:0] = state_reg.irq_status;
          end
          mdfs_pkg::IRQ_MASK_OFFSET: begin
            state_next.rdata[15:0] = state_reg.irq_mask;
          end
          mdfs_pkg::CONFIG_OFFSET: begin
            state_next.rdata[mdfs_pkg::CFG_OC_LIMIT_LSB +: 2] =
              state_reg.cfg.overcurrent_limit_select;
            state_next.rdata[mdfs_pkg::CFG_SHORT_DETECT_BIT] =
              state_reg.cfg.short_circuit_detect_cfg;
          end
          default: begin
            state_next.rdata = '0;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // the brownout flag comes out of reset set: the configuration is lost by definition
      state_reg.status_a   <= mdfs_pkg::STATUS_A_RESET;
      state_reg.status_b   <= mdfs_pkg::STATUS_B_RESET;
      state_reg.reset_seen <= 1'b0;
      state_reg.irq_status <= mdfs_pkg::IRQ_STATUS_RESET;
      state_reg.irq_mask   <= mdfs_pkg::IRQ_MASK_RESET;
      state_reg.cfg        <= mdfs_pkg::mdfs_cfg_t'(mdfs_pkg::CONFIG_RESET[2:0]);
      state_reg.rdata      <= '0;
      state_reg.slverr     <= 1'b0;
      state_reg.irq        <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  // pslverr is gated by the access phase so it never shows in setup or idle
  assign pslverr = access_phase && state_reg.slverr;
  assign prdata  = state_reg.rdata;
  assign cfg     = state_reg.cfg;
  // registered so that it cannot glitch while status and mask update
  assign irq     = state_reg.irq;

endmodule

`default_nettype wire

// ---- rtl/mdfs_pkg.sv ----
// package: register map, field layout and carrier types of the fault status block
package mdfs_pkg;

  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] STATUS_A_OFFSET   = 8'h00;
  localparam logic [7:0] STATUS_B_OFFSET   = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFFSET   = 8'h0C;
  localparam logic [7:0] CONFIG_OFFSET     = 8'h10;

  // ************************************************************
  // status register a field positions
  // ************************************************************
  localparam int A_BUCK_LOW_FAULT_BIT       = 7;
  localparam int A_BUCK_LOW_WARNING_BIT     = 6;
  localparam int A_BUCK_INPUT_OC_WARN_BIT   = 5;
  localparam int A_SUPPLY_OV_FAULT_BIT      = 4;
  localparam int A_DRIVER_OV_FAULT_BIT      = 3;
  localparam int A_SUPPLY_UV_FAULT_BIT      = 2;
  localparam int A_OVERTEMP_FAULT_BIT       = 1;
  localparam int A_OVERTEMP_WARNING_BIT     = 0;

  // ************************************************************
  // status register b field positions
  // ************************************************************
  localparam int B_FIVE_VOLT_LOW_BIT        = 5;
  localparam int B_BROWNOUT_LOST_BIT        = 4;
  localparam int B_EXT_FET_OC_FAULT_BIT     = 3;
  localparam int B_GATE_DRIVE_LOW_BIT       = 2;
  localparam logic [7:0] STATUS_B_IMPL_MASK = 8'h3C;

  // ************************************************************
  // config register field positions
  // ************************************************************
  localparam int CFG_OC_LIMIT_LSB           = 0;
  localparam int CFG_SHORT_DETECT_BIT       = 2;
  localparam logic [7:0] CONFIG_WRITE_MASK  = 8'h07;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0]  STATUS_A_RESET    = 8'h00;
  localparam logic [7:0]  STATUS_B_RESET    = 8'h10;
  localparam logic [15:0] IRQ_STATUS_RESET  = 16'h0000;
  localparam logic [15:0] IRQ_MASK_RESET    = 16'h0000;
  localparam logic [7:0]  CONFIG_RESET      = 8'h00;

  // ************************************************************
  // overcurrent limit encodings: 0.250 V, 0.500 V, 0.750 V, 1.000 V
  // ************************************************************
  localparam logic [1:0] OC_LIMIT_0V250     = 2'h0;
  localparam logic [1:0] OC_LIMIT_0V500     = 2'h1;
  localparam logic [1:0] OC_LIMIT_0V750     = 2'h2;
  localparam logic [1:0] OC_LIMIT_1V000     = 2'h3;

  // ************************************************************
  // carrier types
  // ************************************************************
  // analog monitor comparator outputs, one bit each, high while condition holds
  typedef struct packed {
    logic       buck_low_fault;
    logic       buck_low_warning;
    logic       buck_input_overcurrent_warning;
    logic       supply_overvoltage_fault;
    logic       driver_overvoltage_fault;
    logic       supply_undervoltage_fault;
    logic       overtemp_fault;
    logic       overtemp_warning;
    logic       five_volt_reg_low_fault;
    logic       gate_drive_low_fault;
    logic [3:0] vds_above_limit;
    logic       internal_reset;
  } mdfs_mon_t;

  localparam int MON_W = $bits(mdfs_mon_t);

  typedef struct packed {
    logic [1:0] overcurrent_limit_select;
    logic       short_circuit_detect_cfg;
  } mdfs_cfg_t;

endpackage

// ---- rtl/mdfs_sync.sv ----
// two-flop synchroniser for the analog monitor levels
`timescale 1ns/10ps
`default_nettype none

module mdfs_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } mdfs_sync_state_t;

  mdfs_sync_state_t state_reg;
  mdfs_sync_state_t state_next;

  // the first stage feeds only the second stage
  always_comb begin
    state_next        = state_reg;
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;

endmodule

`default_nettype wire

// ---- sim/mdfs_regs_properties.sv ----
// checker: bus and status relations of the fault status register bank
`timescale 1ns/10ps
`default_nettype none

module mdfs_regs_chk #(
  parameter bit HAS_DRIVER_OVP = 1'b1
) (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [mdfs_pkg::ADDR_W-1:0] paddr,
  input wire logic [mdfs_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0]                  pstrb,
  input wire logic [mdfs_pkg::DATA_W-1:0] prdata,
  input wire logic                        pready,
  input wire logic                        pslverr,
  input wire mdfs_pkg::mdfs_mon_t         monitors,
  input wire mdfs_pkg::mdfs_cfg_t         cfg,
  input wire logic                        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic rd;
  logic mapped;
  logic cfg_wr;
  assign acc    = psel && penable;
  assign rd     = acc && !pwrite;
  assign cfg_wr = acc && pwrite && paddr == mdfs_pkg::CONFIG_OFFSET;
  assign mapped = paddr inside {mdfs_pkg::STATUS_A_OFFSET, mdfs_pkg::STATUS_B_OFFSET, mdfs_pkg::IRQ_STATUS_OFFSET,
                                mdfs_pkg::IRQ_MASK_OFFSET, mdfs_pkg::CONFIG_OFFSET};
  // ************************************************************
  // properties
  // ************************************************************
  // monitor levels need sync plus status flop plus setup capture before a read shows them
  sequence steady_mon;
    $stable(monitors)[*6];
  endsequence
  sequence steady_cfg;
    $stable(monitors)[*2] ##1 ($stable(monitors) && $stable(cfg))[*4];
  endsequence
  ready_always_a: assert property (pready) else $error("pready low");
  unmapped_err_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0) else $error("unmapped no error");
  mapped_ok_a: assert property (acc && mapped |-> !pslverr) else $error("mapped access errored");
  stat_b_rsvd_a: assert property (rd && paddr == mdfs_pkg::STATUS_B_OFFSET |->
    prdata[31:6] == 26'h0 && prdata[1:0] == 2'h0) else $error("status b reserved bits set");
  cfg_load_a: assert property (cfg_wr && pstrb[0] |=> cfg.overcurrent_limit_select == $past(pwdata[1:0]) &&
    cfg.short_circuit_detect_cfg == $past(pwdata[2])) else $error("config not loaded");
  cfg_hold_a: assert property (!cfg_wr |=> $stable(cfg)) else $error("config changed unwritten");
  stat_a_follow_a: assert property (steady_mon ##0 (rd && paddr == mdfs_pkg::STATUS_A_OFFSET) |->
    prdata[7:0] == (monitors[14:7] & (HAS_DRIVER_OVP ? 8'hFF : 8'hF7))) else $error("status a mismatch");
  stat_b_follow_a: assert property (steady_cfg ##0 (rd && paddr == mdfs_pkg::STATUS_B_OFFSET) |->
    prdata[5] == monitors.five_volt_reg_low_fault && prdata[2] == monitors.gate_drive_low_fault &&
    prdata[3] == monitors.vds_above_limit[cfg.overcurrent_limit_select]) else $error("status b mismatch");
endmodule

bind mdfs_regs mdfs_regs_chk #(.HAS_DRIVER_OVP(HAS_DRIVER_OVP)) i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .monitors(monitors), .cfg(cfg), .irq(irq));

`default_nettype wire

// ---- sim/mdfs_mon_model.sv ----
// model: analog monitor comparators that feed the status block
`timescale 1ns/10ps
`default_nettype none

module mdfs_mon_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire mdfs_pkg::mdfs_mon_t req,
  output mdfs_pkg::mdfs_mon_t      monitors
);
  // a higher overcurrent threshold crossed implies every lower one is crossed too
  logic [3:0] vds_fill;
  assign vds_fill = req.vds_above_limit | (req.vds_above_limit >> 1) | (req.vds_above_limit >> 2)
                    | (req.vds_above_limit >> 3);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitors <= '0;
    end else begin
      monitors <= {req[14:5], vds_fill, req.internal_reset};
    end
  end
endmodule

`default_nettype wire

// ---- sim/mdfs_regs_tb.sv ----
// testbench: apb reads and writes against the fault status register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end

module mdfs_regs_tb;
  logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, prdata_novp, rd, rd_novp;
  logic [3:0]          pstrb;
  mdfs_pkg::mdfs_mon_t mon_req, monitors;
  mdfs_pkg::mdfs_cfg_t cfg;
  int                  bad_count, n_tests, cyc;

  mdfs_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .monitors(monitors),
    .cfg(cfg), .irq(irq));
  // variant without the driver supply monitor shares the bus
  mdfs_regs #(.HAS_DRIVER_OVP(1'b0)) i_dut_novp (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_novp), .pready(), .pslverr(),
    .monitors(monitors), .cfg(), .irq());
  mdfs_mon_model i_mon (.pclk(pclk), .presetn(presetn), .req(mon_req), .monitors(monitors));

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for pready; only the bench timeout ends a stuck access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    rd_novp = prdata_novp;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic mon_set(input logic [14:0] v);
    @(posedge pclk);
    mon_req <= mdfs_pkg::mdfs_mon_t'(v);
    repeat (6) @(posedge pclk);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    mon_req = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, 8'h00, 32'h0, 4'h0); `CHK("status_a reset", 32'h0, rd)
    xfer(1'b0, 8'h04, 32'h0, 4'h0); `CHK("status_b reset", 32'h10, rd)
    $display("test reset done");
    // one-hot walk also proves the previous flag dropped without latching
    for (int i = 0; i < 8; i++) begin
      mon_set(15'h80 << i);
      xfer(1'b0, 8'h00, 32'h0, 4'h0); `CHK("status_a flag", 32'h1 << i, rd)
      `CHK("status_a variant", (i == 3) ? 32'h0 : 32'h1 << i, rd_novp)
    end
    mon_set(15'h0);
    xfer(1'b1, 8'h00, 32'hFF, 4'hF);
    xfer(1'b0, 8'h00, 32'h0, 4'h0); `CHK("status_a clear", 32'h0, rd)
    $display("test status_a done");
    mon_set(15'h7FFE);
    xfer(1'b0, 8'h04, 32'h0, 4'h0); `CHK("status_b all", 32'h3C, rd)
    xfer(1'b0, 8'h04, 32'h0, 4'h0); `CHK("status_b reread", 32'h3C, rd)
    `CHK("mapped err", 1'b0, err)
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, 8'h10, 32'h4 | c, 4'hF);
      xfer(1'b0, 8'h10, 32'h0, 4'h0); `CHK("cfg read", 32'h4 | c, rd)
      mon_set(15'h2 << c);
      `CHK("cfg out", {c[1:0], 1'b1}, cfg)
      xfer(1'b0, 8'h04, 32'h0, 4'h0); `CHK("oc above", 32'h08, rd)
      mon_set((15'h1 << c) & 15'h7FFE);
      xfer(1'b0, 8'h04, 32'h0, 4'h0); `CHK("oc below", 32'h0, rd)
    end
    $display("test status_b done");
    mon_set(15'h1);
    mon_set(15'h0);
    xfer(1'b0, 8'h04, 32'h0, 4'h0); `CHK("brownout set", 32'h10, rd)
    xfer(1'b1, 8'h10, 32'h4, 4'h0);
    xfer(1'b0, 8'h04, 32'h0, 4'h0); `CHK("brownout kept", 32'h10, rd)
    xfer(1'b1, 8'h10, 32'h4, 4'h1);
    xfer(1'b0, 8'h04, 32'h0, 4'h0); `CHK("brownout clear", 32'h0, rd)
    xfer(1'b0, 8'h20, 32'h0, 4'h0); `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    $display("test brownout done");
    xfer(1'b0, 8'h08, 32'h0, 4'h0);
    xfer(1'b1, 8'h0C, 32'h1, 4'hF);
    xfer(1'b0, 8'h0C, 32'h0, 4'h0); `CHK("irq mask read", 32'h1, rd)
    @(negedge pclk); `CHK("irq idle", 1'b0, irq)
    mon_set(15'h80);
    `CHK("irq raised", 1'b1, irq)
    xfer(1'b0, 8'h08, 32'h0, 4'h0); `CHK("irq status", 32'h1, rd)
    @(negedge pclk); `CHK("irq cleared", 1'b0, irq)
    xfer(1'b1, 8'h0C, 32'h0, 4'hF);
    mon_set(15'h0);
    mon_set(15'h80);
    `CHK("irq masked", 1'b0, irq)
    $display("test irq done");
    summarize();
  end
endmodule

`default_nettype wire
